// file: core/dotc_timer.sv
// One 16-bit timer channel with prescaler, two wave outputs, capture.
// Assumes asynchronous pins and a one-cycle strobe register port.
`timescale 1ns/1ns
`default_nettype none
//
// Overview of operation
// - Own 16-bit up-counter fed by a 12-bit prescaler, two outputs
// - General purpose 16-bit timer with outputs A and B
// - Modes: interval, one-shot, back-to-back, capture
// - Counter may be taken from a linked neighbour channel
// - Synchronous start and clear inputs shared by several channels
// - Interval mode raises period, A, B interrupts, never bottom
// - Capture mode raises period and capture interrupts only
// - Capture edge copies count to holding value, then clears count
// - One-shot clears run enable itself after one pulse
// - Counting starts two or more counting clocks after enable
// - One input pin serves as capture trigger or force input
module dotc_timer
    import dotc_pkg::*;
#(
    parameter int CW = CNT_W,
    parameter int PW = PRE_W
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic [3:0]    addr,
    input  wire logic [15:0]   wdata,
    input  wire logic          wr,
    input  wire logic          rd,
    output logic [15:0]        rdata,
    input  wire logic          ext_count_clock_in,
    input  wire logic          capture_force_in,
    input  wire logic          sync_start,
    input  wire logic          sync_clear,
    input  wire logic [CW-1:0] link_count_in,
    output logic [CW-1:0]      link_count_out,
    output logic               wave_out_a,
    output logic               wave_out_b,
    output logic               irq
);
    ////////////////////////////////////////////////////////////////////
    dotc_bus_t  bus;
    logic [7:0] ctrl_r;
    logic [PW-1:0] pre_r;
    logic [PW-1:0] pre_cnt_r;
    logic [CW-1:0] period_r;
    logic [CW-1:0] cmpa_r;
    logic [CW-1:0] cmpb_r;
    logic [CW-1:0] count_value;
    logic [CW-1:0] capture_holding_value;
    logic [ST_W-1:0] stat_r;
    logic [ST_W-1:0] mask_r;
    logic [1:0]    lat_r;
    logic          ec_lvl;
    logic          ec_rise;
    logic          in_lvl;
    logic          in_rise;
    logic          in_fall;
    logic          tick;
    logic          cap_edge;
    logic          step;
    logic          per_hit;
    logic          a_hit;
    logic          b_hit;
    logic          oneshot_done;
    logic [ST_W-1:0] ev;
    logic [CW-1:0] cur;
    dotc_mode_t    mode;
    logic          cap_hit;
    logic          clr_hit;
    logic          wave_idle;
    logic [CW-1:0] count_nxt;
    logic [ST_W-1:0] stat_nxt;
    logic [15:0]   rdata_nxt;

    assign bus = '{wr: wr, rd: rd, addr: addr, wdata: wdata};
    assign mode = dotc_mode_t'(ctrl_r[CTL_MODE_LO +: 2]);

    ////////////////////////////////////////////////////////////////////
    // Pin sampling
    // Two flops before the edge stage; edges act about three cycles late
    dotc_edge u_ec (
        .clk   (clk),
        .rst   (rst),
        .pin   (ext_count_clock_in),
        .level (ec_lvl),
        .rise  (ec_rise),
        .fall  ()
    );
    dotc_edge u_in (
        .clk   (clk),
        .rst   (rst),
        .pin   (capture_force_in),
        .level (in_lvl),
        .rise  (in_rise),
        .fall  (in_fall)
    );

    assign cap_edge = ctrl_r[CTL_CAPFALL] ? in_fall : in_rise;

    ////////////////////////////////////////////////////////////////////
    // Prescaler: divider output is a one-cycle counting enable
    // Held at zero while stopped, so every start gets a full division
    always_ff @(posedge clk) begin
        if (rst || !ctrl_r[CTL_EN]) begin
            pre_cnt_r <= ZERO12;
        end else if (ctrl_r[CTL_EXTCLK] ? ec_rise : 1'b1) begin
            pre_cnt_r <= (pre_cnt_r >= pre_r) ? ZERO12 : pre_cnt_r + 1'b1;
        end
    end
    assign tick = ctrl_r[CTL_EN] &&
                  (ctrl_r[CTL_EXTCLK] ? ec_rise : 1'b1) &&
                  (pre_cnt_r >= pre_r);

    // Start latency in counting clocks
    always_ff @(posedge clk) begin
        if (rst || !ctrl_r[CTL_EN]) begin
            lat_r <= START_LAT;
        end else if (tick && lat_r != 2'h0) begin
            lat_r <= lat_r - 1'b1;
        end
    end
    assign step = tick && (lat_r == 2'h0);

    ////////////////////////////////////////////////////////////////////
    // Counter; linked mode matches on the neighbour's count, own count runs on
    assign cur = ctrl_r[CTL_LINK] ? link_count_in : count_value;
    assign per_hit = step && (cur == period_r);
    assign a_hit = step && (cur == cmpa_r) && mode != DOTC_CAPTURE;
    assign b_hit = step && (cur == cmpb_r) && mode != DOTC_CAPTURE;
    assign oneshot_done = per_hit && mode == DOTC_ONESHOT;
    assign cap_hit = mode == DOTC_CAPTURE && ctrl_r[CTL_EN] && cap_edge;
    // Clear bit is self-clearing, so it acts from the write data itself
    assign clr_hit = bus.wr && bus.addr == OFF_CTRL && bus.wdata[CTL_CLR];

    // Clears take priority over counting in the same cycle
    always_comb begin
        count_nxt = count_value;
        if (sync_clear || clr_hit) begin
            count_nxt = ZERO16;
        end else if (cap_hit) begin
            count_nxt = ZERO16;
        end else if (step) begin
            if (count_value == period_r) begin
                count_nxt = ZERO16;
            end else begin
                count_nxt = count_value + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count_value <= ZERO16;
        end else begin
            count_value <= count_nxt;
        end
    end
    assign link_count_out = count_value;

    // Holding value is the count before the capture clear lands
    always_ff @(posedge clk) begin
        if (rst) begin
            capture_holding_value <= ZERO16;
        end else if (cap_hit) begin
            capture_holding_value <= count_value;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Waveform outputs; outside capture mode the pin is a force input
    // Force holds both outputs idle while asserted; back-to-back ignores it
    assign wave_idle = mode == DOTC_CAPTURE || !ctrl_r[CTL_EN] ||
                       (in_lvl && mode != DOTC_B2B);

    always_ff @(posedge clk) begin
        if (rst) begin
            wave_out_a <= 1'b0;
        end else if (wave_idle || per_hit) begin
            wave_out_a <= ctrl_r[CTL_POL];
        end else if (a_hit) begin
            wave_out_a <= ~wave_out_a;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wave_out_b <= 1'b0;
        end else if (wave_idle) begin
            wave_out_b <= ctrl_r[CTL_POL];
        end else if (per_hit) begin
            // Back-to-back starts each period with B opposite to A
            wave_out_b <= (mode == DOTC_B2B) ? ~ctrl_r[CTL_POL]
                                             : ctrl_r[CTL_POL];
        end else if (b_hit) begin
            wave_out_b <= ~wave_out_b;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control and config registers
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r <= 8'h00;
        end else if (bus.wr && bus.addr == OFF_CTRL) begin
            ctrl_r <= bus.wdata[7:0];
            ctrl_r[CTL_CLR] <= 1'b0;
        end else if (oneshot_done) begin
            ctrl_r[CTL_EN] <= 1'b0;
        end else if (sync_start) begin
            ctrl_r[CTL_EN] <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pre_r <= ZERO12;
            period_r <= RST_PERIOD;
            cmpa_r <= ZERO16;
            cmpb_r <= ZERO16;
        end else if (bus.wr) begin
            unique case (bus.addr)
                OFF_PRE: pre_r <= bus.wdata[PW-1:0];
                OFF_PERIOD: period_r <= bus.wdata;
                OFF_CMPA: cmpa_r <= bus.wdata;
                OFF_CMPB: cmpb_r <= bus.wdata;
                default: ;
            endcase
        end
    end

    // Mask kept apart: it only gates the interrupt pin
    always_ff @(posedge clk) begin
        if (rst) begin
            mask_r <= '0;
        end else if (bus.wr && bus.addr == OFF_MASK) begin
            mask_r <= bus.wdata[ST_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sticky status; a new event wins over a write-one clear
    always_comb begin
        ev = '0;
        ev[ST_PER] = per_hit;
        ev[ST_A] = a_hit;
        ev[ST_B] = b_hit;
        ev[ST_CAP] = cap_hit;
    end

    always_comb begin
        stat_nxt = stat_r | ev;
        if (bus.wr && bus.addr == OFF_STAT) begin
            stat_nxt = (stat_r & ~bus.wdata[ST_W-1:0]) | ev;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stat_r <= '0;
        end else begin
            stat_r <= stat_nxt;
        end
    end

    // Registered so the pin comes from a flop; costs one cycle of delay
    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stat_r & mask_r);
        end
    end

    // Read mux; data stand one cycle after the strobe, zero otherwise
    always_comb begin
        rdata_nxt = ZERO16;
        if (bus.rd) begin
            unique case (bus.addr)
                OFF_CTRL: rdata_nxt = {8'h00, ctrl_r};
                OFF_PRE: rdata_nxt = {4'h0, pre_r};
                OFF_PERIOD: rdata_nxt = period_r;
                OFF_CMPA: rdata_nxt = cmpa_r;
                OFF_CMPB: rdata_nxt = cmpb_r;
                OFF_CNT: rdata_nxt = count_value;
                OFF_CAP: rdata_nxt = capture_holding_value;
                OFF_STAT: rdata_nxt = {12'h000, stat_r};
                OFF_MASK: rdata_nxt = {12'h000, mask_r};
                default: rdata_nxt = ZERO16;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= ZERO16;
        end else begin
            rdata <= rdata_nxt;
        end
    end
endmodule
`default_nettype wire

// file: core/dotc_pkg.sv
// Constants, register map and types for the dual output timer channel.
// Assumes one 125 MHz clock and a plain strobe register port.
package dotc_pkg;

    localparam int CNT_W = 16;
    localparam int PRE_W = 12;
    localparam int ADDR_W = 4;

    // Register word offsets
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_PRE = 4'h1;
    localparam logic [3:0] OFF_PERIOD = 4'h2;
    localparam logic [3:0] OFF_CMPA = 4'h3;
    localparam logic [3:0] OFF_CMPB = 4'h4;
    localparam logic [3:0] OFF_CNT = 4'h5;
    localparam logic [3:0] OFF_CAP = 4'h6;
    localparam logic [3:0] OFF_STAT = 4'h7;
    localparam logic [3:0] OFF_MASK = 4'h8;

    // Control field positions
    localparam int CTL_EN = 0;
    localparam int CTL_MODE_LO = 1;
    localparam int CTL_EXTCLK = 3;
    localparam int CTL_CAPFALL = 4;
    localparam int CTL_LINK = 5;
    localparam int CTL_CLR = 6;
    localparam int CTL_POL = 7;

    // Status bits: period, A, B, capture
    localparam int ST_PER = 0;
    localparam int ST_A = 1;
    localparam int ST_B = 2;
    localparam int ST_CAP = 3;
    localparam int ST_W = 4;

    localparam logic [15:0] RST_PERIOD = 16'hffff;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [11:0] ZERO12 = 12'h000;
    // Counting clocks swallowed after enable
    localparam logic [1:0] START_LAT = 2'h2;

    typedef enum logic [1:0] {
        DOTC_INTERVAL,
        DOTC_ONESHOT,
        DOTC_B2B,
        DOTC_CAPTURE
    } dotc_mode_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [15:0] wdata;
    } dotc_bus_t;

endpackage

// file: core/dotc_edge.sv
// Synchroniser plus edge detector for one pin input.
// Assumes the pin level is held longer than one clock period.
`timescale 1ns/1ns
`default_nettype none
module dotc_edge (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    // First stage feeds the second only
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= pin;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign level = sync_r;
    assign rise = sync_r & ~last_r;
    assign fall = ~sync_r & last_r;
endmodule
`default_nettype wire

// file: sim/dotc_props.sv
// Concurrent checks on the timer channel's top ports.
// Assumes one clock; mirrors control and mask writes itself.
`timescale 1ns/1ns
`default_nettype none
module dotc_props
    import dotc_pkg::*;
#(parameter int CW = CNT_W) (
    input wire logic          clk,
    input wire logic          rst,
    input wire logic [3:0]    addr,
    input wire logic [15:0]   wdata,
    input wire logic          wr,
    input wire logic          rd,
    input wire logic [15:0]   rdata,
    input wire logic          ext_count_clock_in,
    input wire logic          capture_force_in,
    input wire logic          sync_start,
    input wire logic          sync_clear,
    input wire logic [CW-1:0] link_count_in,
    input wire logic [CW-1:0] link_count_out,
    input wire logic          wave_out_a,
    input wire logic          wave_out_b,
    input wire logic          irq
);
    logic [7:0] ctrl_r;
    logic [3:0] mask_r;
    ////////////////////////////////////////////////////////////////////
    // Enable may be stale after a one-shot; every use tolerates that
    always_ff @(posedge clk) begin
        if (rst)
            ctrl_r <= 8'h00;
        else if (wr && addr == OFF_CTRL)
            ctrl_r <= wdata[7:0];
    end
    always_ff @(posedge clk) begin
        if (rst)
            mask_r <= 4'h0;
        else if (wr && addr == OFF_MASK)
            mask_r <= wdata[3:0];
    end
    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("read data not zero outside answer");
    a_unmapped_zero: assert property (
        $past(rd && addr > OFF_MASK) |-> rdata == ZERO16)
        else $error("unmapped read not zero");
    a_stat_bits: assert property (
        $past(rd && addr == OFF_STAT) |-> rdata[15:4] == 12'h000)
        else $error("status has bits beyond four");
    a_count_step: assert property (
        !ctrl_r[5] && link_count_out != $past(link_count_out) |->
        link_count_out == $past(link_count_out) + 1'b1 ||
        link_count_out == ZERO16)
        else $error("count moved other than up by one or to zero");
    a_irq_masked: assert property (mask_r == 4'h0 |=> !irq)
        else $error("interrupt high with all masked");
    a_cap_clear: assert property (
        ctrl_r[2:0] == 3'h7 && !ctrl_r[4] && $rose(capture_force_in)
        |-> ##[2:6] link_count_out == ZERO16)
        else $error("capture edge did not clear count");
    a_start_delay: assert property (
        wr && addr == OFF_CTRL && wdata[0] && !wdata[3] && !ctrl_r[0] &&
        !wdata[6] && !sync_clear
        |=> $stable(link_count_out)[*2])
        else $error("count moved too soon after enable");
    a_count_ro: assert property (
        wr && addr == OFF_CNT && !ctrl_r[0] && !sync_clear
        |=> $stable(link_count_out))
        else $error("count changed by a write");
    a_soft_clear: assert property (
        wr && addr == OFF_CTRL && wdata[6] |=> link_count_out == ZERO16)
        else $error("clear bit did not zero the count");
endmodule
bind dotc_timer dotc_props #(.CW(CW)) u_props (.*);
`default_nettype wire

// file: sim/dotc_pins.sv
// Pin-side partner: external count clock and capture/force input.
// Assumes the bench raises cap_go for one cycle per capture event.
`timescale 1ns/1ns
`default_nettype none
module dotc_pins (
    input  wire logic clk,
    input  wire logic ext_on,
    input  wire logic cap_go,
    output logic      ext_count_clock_in,
    output logic      capture_force_in
);
    logic [1:0] div_r = 2'h0;
    logic [2:0] hold_r = 3'h0;
    initial ext_count_clock_in = 1'b0;
    // Three cycles a phase keeps each level above one clock period
    always @(posedge clk) begin
        div_r <= (div_r == 2'h2) ? 2'h0 : div_r + 2'h1;
        if (!ext_on)
            ext_count_clock_in <= 1'b0;
        else if (div_r == 2'h2)
            ext_count_clock_in <= ~ext_count_clock_in;
    end
    always @(posedge clk) begin
        hold_r <= cap_go ? 3'h4 : hold_r - {2'h0, hold_r != 3'h0};
    end
    assign capture_force_in = hold_r != 3'h0;
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the dual output timer channel.
// Assumes dotc_timer, the pin partner and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import dotc_pkg::*;
    logic        clk, rst, wr, rd, cap_go, ext_on, s_st, s_cl;
    logic        ext_ck, cap_in, wa, wb, irq;
    logic [3:0]  addr;
    logic [15:0] wdata, rdata, lin, lout, v;
    int          n_errors, samples_checked, toggles, m[16];

    dotc_timer i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .ext_count_clock_in(ext_ck),
        .capture_force_in(cap_in), .sync_start(s_st), .sync_clear(s_cl),
        .link_count_in(lin), .link_count_out(lout), .wave_out_a(wa),
        .wave_out_b(wb), .irq(irq));
    dotc_pins i_pins (.clk(clk), .ext_on(ext_on), .cap_go(cap_go),
        .ext_count_clock_in(ext_ck), .capture_force_in(cap_in));
    ////////////////////////////////////////////////////////////////////
    task automatic chk16(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk16({15'h0, g}, {15'h0, e});
    endtask
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        if (a inside {[OFF_PRE:OFF_CMPB], OFF_MASK})
            m[a] = d;
    endtask
    task automatic rreg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    // Sync lines are pulses; either clear or start, never both at once
    task automatic sync_pulse(input logic st);
        @(posedge clk);
        s_cl <= ~st;
        s_st <= st;
        @(posedge clk);
        s_cl <= 1'b0;
        s_st <= 1'b0;
        repeat (4) @(negedge clk);
    endtask
    task automatic run(input logic [15:0] c, input int n);
        wreg(OFF_STAT, 16'h000f);
        wreg(OFF_CTRL, c);
        repeat (n) @(posedge clk);
    endtask
    task automatic wrap_up;
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(wa or wb) toggles++;
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        wrap_up;
    end
    initial begin
        {wr, rd, cap_go, ext_on, s_st, s_cl} = 6'h00;
        {addr, wdata, lin, rst} = {4'h0, 16'h0000, 16'h0000, 1'b1};
        {n_errors, samples_checked} = {32'sd0, 32'sd0};
        foreach (m[i]) m[i] = 0;
        m[OFF_PERIOD] = 32'hffff;
        void'($urandom(32'h215b05e4));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        lin <= 16'($urandom);
        for (int i = 1; i < 6; i++) wreg(4'(i), 16'($urandom) & 16'h0fff);
        wreg(4'hc, 16'($urandom));
        wreg(OFF_MASK, 16'($urandom) & 16'h000f);
        for (int i = 0; i < 16; i++) begin
            rreg(4'(i), v);
            chk16(v, m[i][15:0]);
        end
        $display("registers done");
        wreg(OFF_PRE, 16'h0000);
        wreg(OFF_PERIOD, 16'h0009);
        wreg(OFF_CMPA, 16'h0003);
        wreg(OFF_CMPB, 16'h0006);
        wreg(OFF_MASK, 16'h000f);
        toggles = 0;
        wreg(OFF_STAT, 16'h000f);
        wreg(OFF_CTRL, 16'h0001);
        // Two ticks swallowed, then A matches at 3 and B at 6
        repeat (8) @(negedge clk);
        chk1(wa, 1'b1);
        chk1(wb, 1'b0);
        repeat (3) @(negedge clk);
        chk1(wa, 1'b1);
        chk1(wb, 1'b1);
        // Force pulse over the next A match keeps A idle
        @(posedge clk);
        cap_go <= 1'b1;
        @(posedge clk);
        cap_go <= 1'b0;
        repeat (6) @(negedge clk);
        chk1(wa, 1'b0);
        repeat (30) @(posedge clk);
        wreg(OFF_CTRL, 16'h0000);
        rreg(OFF_STAT, v);
        chk16(v, 16'h0007);
        chk1(toggles > 0, 1'b1);
        chk1(irq, 1'b1);
        wreg(OFF_MASK, 16'h0000);
        repeat (2) @(negedge clk);
        chk1(irq, 1'b0);
        wreg(OFF_MASK, 16'h000f);
        wreg(OFF_STAT, 16'h0007);
        rreg(OFF_STAT, v);
        chk16(v, 16'h0000);
        chk1(irq, 1'b0);
        $display("interval done");
        run(16'h0003, 40);
        rreg(OFF_CTRL, v);
        chk1(v[0], 1'b0);
        run(16'h0005, 30);
        wreg(OFF_CTRL, 16'h0000);
        rreg(OFF_STAT, v);
        chk1(v[0], 1'b1);
        $display("one-shot and back-to-back done");
        // Linked count drives the matches; own count stays far below
        wreg(OFF_PERIOD, 16'h0100);
        lin <= 16'h0100;
        run(16'h0021, 10);
        wreg(OFF_CTRL, 16'h0000);
        rreg(OFF_STAT, v);
        chk16(v & 16'h0007, 16'h0001);
        wreg(OFF_PERIOD, 16'hffff);
        sync_pulse(1'b0);
        chk16(lout, 16'h0000);
        sync_pulse(1'b1);
        repeat (20) @(negedge clk);
        chk1(lout != 16'h0000, 1'b1);
        wreg(OFF_CTRL, 16'h0040);
        @(negedge clk);
        chk16(lout, 16'h0000);
        rreg(OFF_CTRL, v);
        chk16(v, 16'h0000);
        sync_pulse(1'b0);
        run(16'h0007, 30);
        cap_go <= 1'b1;
        @(posedge clk);
        cap_go <= 1'b0;
        repeat (10) @(negedge clk);
        rreg(OFF_CAP, v);
        chk1(v > 16'h0010 && v < 16'h0040, 1'b1);
        chk1(lout < v, 1'b1);
        rreg(OFF_STAT, v);
        chk16(v & 16'h000e, 16'h0008);
        wreg(OFF_CTRL, 16'h0000);
        $display("sync and capture done");
        sync_pulse(1'b0);
        ext_on <= 1'b1;
        wreg(OFF_CTRL, 16'h0009);
        repeat (60) @(negedge clk);
        chk1(lout > 16'h0003 && lout < 16'h000c, 1'b1);
        ext_on <= 1'b0;
        wreg(OFF_CTRL, 16'h0080);
        @(negedge clk);
        chk1(wa & wb, 1'b1);
        $display("external clock done");
        wrap_up;
    end
endmodule
`default_nettype wire
